//--- core/operand_channel_check_logic.sv
// Purpose: Operand channel validity, holding register and select checks
// Assumes: Datapath strobes share pclk; check-test switches are asynchronous
// Notes: Errors are judged only at the end-of-cycle sample strobe
// How it works
// - Each storage cycle the read channel character is tested for odd ones, else stop.
// - The character splits into pairs 1/8, 2/4, A/B and check/mark, each giving odd and even.
// - Numeric pairs merge to a numeric odd/even, zone and check/mark pairs to a second one.
// - A last stage gives character odd and even; even at the error sample is an error.
// - An error is even or not odd, catching bad counts, broken rails and stuck lines.
// - Both checkers also give a numeric and a zone check bit for the assembly unit.
// - The second test input forces numeric odd and even, so the character check fails.
// - The third test input forces zone-mark-check odd and even, so the check fails.
// - The holding register loads from the read path or the address exit path and holds.
// - A clear sets the holding register to zero except the check bit.
// - A load toggle and a clear toggle must agree at each end of cycle, else stop.
// - The second operand channel takes one of holding, two I/O registers or modifier.
// - No gate or several gates on the operand channel is an error at the sample.
// - Test one blocks all gates; tests two and three each force a multiple-select error.
`timescale 1ns/1ps
`default_nettype none
module operand_channel_check_logic (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire occ_pkg::rail_char_t read_path,
  input wire logic [7:0] address_exit_path,
  input wire logic load_hold_from_read_path,
  input wire logic load_hold_from_address_path,
  input wire logic clear_hold,
  input wire logic [3:0] source_gate,
  input wire logic [7:0] io_data_reg_one,
  input wire logic [7:0] io_data_reg_two,
  input wire logic [7:0] op_modifier,
  input wire logic error_sample,
  input wire logic [2:0] check_test,
  output logic [7:0] operand_channel,
  output logic [1:0] read_cbits,
  output logic [1:0] operand_cbits,
  output logic [3:0] indicators,
  output logic machine_stop,
  output logic irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] test_meta;
    logic [2:0] test_sync;
    logic [7:0] hold;
    logic load_tgl;
    logic clear_tgl;
    logic [3:0] ind;
    logic [3:0] enable;
    logic stop;
    logic irq;
    logic [7:0] opnd;
    logic [1:0] rd_cb;
    logic [1:0] op_cb;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } state_t;
  state_t s_q;
  state_t s_d;
  occ_pkg::apb_req_t req;
  occ_pkg::vc_res_t read_res;
  occ_pkg::vc_res_t opnd_res;
  occ_pkg::rail_char_t opnd_rail;
  logic [3:0] gate_eff;
  logic [7:0] opnd_mux;
  logic sel_none;
  logic sel_multi;
  logic [3:0] err_now;
  logic access;
  logic mapped;
  // Verdict of a dual-rail check: even, or not odd
  function automatic logic vc_error(input occ_pkg::vc_res_t r);
    vc_error = r.even | ~r.odd;
  endfunction : vc_error
  // True if more than one bit of a gate vector is set
  function automatic logic many(input logic [3:0] g);
    many = (g[0] & g[1]) | (g[0] & g[2]) | (g[0] & g[3]) | (g[1] & g[2]) |
           (g[1] & g[3]) | (g[2] & g[3]);
  endfunction : many
  // ----------------------------------------------------------------
  // Operand channel source select and checkers
  // ----------------------------------------------------------------
  always_comb begin
    req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    // Test one blocks every gate so the no-source path must fire
    gate_eff = source_gate & {4{~s_q.test_sync[0]}};
    opnd_mux = ({8{gate_eff[0]}} & s_q.hold) | ({8{gate_eff[1]}} & io_data_reg_one) |
               ({8{gate_eff[2]}} & io_data_reg_two) | ({8{gate_eff[3]}} & op_modifier);
    sel_none = ~|gate_eff;
    // Two distinct multiple-select paths, each forced by its own test line
    sel_multi = (many(gate_eff) | s_q.test_sync[1]) | s_q.test_sync[2];
    opnd_rail = '{t: opnd_mux, c: ~opnd_mux};
  end
  parity_checker u_read_vc (
    .ch(read_path),
    .test_num(s_q.test_sync[1]),
    .test_zone(s_q.test_sync[2]),
    .res(read_res)
  );
  parity_checker u_opnd_vc (
    .ch(opnd_rail),
    .test_num(s_q.test_sync[1]),
    .test_zone(s_q.test_sync[2]),
    .res(opnd_res)
  );
  // Raw errors, meaningful only at the sample strobe
  always_comb begin
    err_now[occ_pkg::IND_READ_VC] = vc_error(read_res);
    err_now[occ_pkg::IND_OPND_VC] = vc_error(opnd_res);
    err_now[occ_pkg::IND_SET_CHK] = s_q.load_tgl ^ s_q.clear_tgl;
    err_now[occ_pkg::IND_SEL_CHK] = sel_none | sel_multi;
    access = req.sel & req.enable & s_q.ready;
    mapped = (req.addr == occ_pkg::OFF_STATUS) | (req.addr == occ_pkg::OFF_CLEAR) |
             (req.addr == occ_pkg::OFF_ENABLE) | (req.addr == occ_pkg::OFF_HOLD);
  end
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Check-test switches come from the console, so synchronise them
    s_d.test_meta = check_test;
    s_d.test_sync = s_q.test_meta;
    // Clear first so a clear and load in one cycle leaves the new character
    if (clear_hold) begin
      s_d.hold = occ_pkg::HOLD_CLEAR_VAL;
      s_d.clear_tgl = ~s_q.clear_tgl;
    end
    if (load_hold_from_read_path | load_hold_from_address_path) begin
      s_d.load_tgl = ~s_q.load_tgl;
    end
    if (load_hold_from_read_path) begin
      s_d.hold = read_path.t;
    end else if (load_hold_from_address_path) begin
      s_d.hold = address_exit_path;
    end
    s_d.opnd = opnd_mux;
    s_d.rd_cb = {read_res.zone_cbit, read_res.num_cbit};
    s_d.op_cb = {opnd_res.zone_cbit, opnd_res.num_cbit};
    // APB: one wait state, then the access completes
    s_d.ready = req.sel & req.enable & ~s_q.ready;
    s_d.slverr = req.sel & req.enable & ~s_q.ready & ~mapped;
    s_d.rdata = 32'h0000_0000;
    if (req.sel & req.enable & ~s_q.ready & ~req.write) begin
      case (req.addr)
        occ_pkg::OFF_STATUS: s_d.rdata = {28'h000_0000, s_q.ind};
        occ_pkg::OFF_ENABLE: s_d.rdata = {28'h000_0000, s_q.enable};
        occ_pkg::OFF_HOLD: s_d.rdata = {24'h00_0000, s_q.hold};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (access & req.write & (req.addr == occ_pkg::OFF_ENABLE)) begin
      s_d.enable = req.wdata[3:0];
    end
    // Clear before set so an error in the same cycle is kept
    if (access & req.write & (req.addr == occ_pkg::OFF_CLEAR)) begin
      s_d.ind = s_q.ind & ~req.wdata[3:0];
    end
    if (error_sample) begin
      s_d.ind = s_d.ind | err_now;
    end
    s_d.stop = |s_d.ind;
    s_d.irq = |(s_d.ind & s_d.enable);
  end
  // ----------------------------------------------------------------
  // Registers, frozen while clk_en is low
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.hold <= occ_pkg::HOLD_CLEAR_VAL;
      s_q.enable <= occ_pkg::ENABLE_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end
  // Outputs straight from flops
  always_comb begin
    prdata = s_q.rdata;
    pready = s_q.ready;
    pslverr = s_q.slverr;
    operand_channel = s_q.opnd;
    read_cbits = s_q.rd_cb;
    operand_cbits = s_q.op_cb;
    indicators = s_q.ind;
    machine_stop = s_q.stop;
    irq = s_q.irq;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence sample_cycle;
    clk_en && error_sample;
  endsequence
  sequence apb_first_access;
    clk_en && psel && penable && !pready;
  endsequence
  // A write of all ones to the clear register, at the edge where it lands
  sequence apb_clear_all;
    clk_en && psel && penable && pready && pwrite && paddr == occ_pkg::OFF_CLEAR
      && pwdata[3:0] == 4'hF;
  endsequence
  // Read channel checker: a bad character at the sample stops the machine
  a_read_vc_stop: assert property (
    sample_cycle ##0 (read_res.even || !read_res.odd)
    |=> indicators[0] && machine_stop) else $error("read check did not stop");
  a_read_even_detect: assert property (
    clk_en && (^read_path.t) == 1'b0
    && read_path.c == ~read_path.t |-> vc_error(read_res)) else $error("even missed");
  // Holding register contents after a clear or a load
  a_hold_clear_val: assert property (
    clk_en && clear_hold && !load_hold_from_read_path && !load_hold_from_address_path
    |=> s_q.hold == occ_pkg::HOLD_CLEAR_VAL) else $error("bad clear");
  a_hold_load_read: assert property (
    clk_en && load_hold_from_read_path
    |=> s_q.hold == $past(read_path.t)) else $error("hold load wrong");
  a_set_chk_toggle: assert property (
    sample_cycle ##0 (s_q.load_tgl != s_q.clear_tgl)
    |=> indicators[2]) else $error("set check missed");
  // Source select checker, normal and forced paths
  a_select_none: assert property (
    sample_cycle ##0 (source_gate == 4'h0)
    |=> indicators[3]) else $error("no-source missed");
  a_test_one_sel: assert property (
    sample_cycle ##0 s_q.test_sync[0]
    |=> indicators[3]) else $error("test one failed");
  a_test_two_all: assert property (
    sample_cycle ##0 s_q.test_sync[1]
    |=> indicators[1:0] == 2'h3 && indicators[3]) else $error("test two");
  a_test_three_vc: assert property (
    sample_cycle ##0 s_q.test_sync[2]
    |=> indicators[0] && indicators[1] && indicators[3]) else $error("test three");
  // Nothing may latch between samples, whatever the channel carries
  a_no_sample_quiet: assert property (
    !error_sample && clk_en
    |=> (indicators & ~$past(indicators)) == 4'h0) else $error("set off sample");
  a_ind_sticky: assert property (
    indicators[0] && !(psel && penable && pwrite)
    |=> indicators[0]) else $error("indicator dropped");
  a_apb_one_wait: assert property (apb_first_access |=> pready ##1 !pready)
    else $error("apb timing");
  // Operand checker shares the stop path with the read checker
  a_opnd_vc_stop: assert property (
    sample_cycle ##0 vc_error(opnd_res)
    |=> indicators[1] && machine_stop) else $error("operand check did not stop");
  // Two live gates at once must light the select indicator
  a_select_multi: assert property (
    sample_cycle ##0 many(source_gate)
    |=> indicators[3]) else $error("multi-select missed");
  // Address path load while the read path is idle
  a_hold_load_addr: assert property (
    clk_en && load_hold_from_address_path && !load_hold_from_read_path
    |=> s_q.hold == $past(address_exit_path)) else $error("address load wrong");
  // A single gate passes its source to the operand channel a cycle later
  a_opnd_gate_pass: assert property (
    clk_en && source_gate == 4'h2 && !s_q.test_sync[0]
    |=> operand_channel == $past(io_data_reg_one)) else $error("gate pass wrong");
  // Addresses past the last register answer with an error
  a_unmapped_err: assert property (
    apb_first_access ##0 (paddr > occ_pkg::OFF_HOLD)
    |=> pready && pslverr) else $error("unmapped not refused");
  // Clearing every bit with no sample pending drops the stop too
  a_clear_all: assert property (
    apb_clear_all ##0 !error_sample
    |=> indicators == 4'h0 && !machine_stop) else $error("clear failed");
endmodule : operand_channel_check_logic
`default_nettype wire

//--- core/parity_checker.sv
// Purpose: Dual-rail odd parity checker for one eight-bit character
// Assumes: Rails arrive settled before the error sample of the cycle
// Notes: Pure combinational; the caller registers the verdict
`timescale 1ns/1ps
`default_nettype none
module parity_checker (
  input wire occ_pkg::rail_char_t ch,
  input wire logic test_num,
  input wire logic test_zone,
  output occ_pkg::vc_res_t res
);
  logic [3:0] p_odd;
  logic [3:0] p_even;
  logic num_odd;
  logic num_even;
  logic zmc_odd;
  logic zmc_even;
  // Pair odd/even from true and complement rails
  function automatic logic [1:0] pair(input logic at, input logic ac, input logic bt,
                                      input logic bc);
    pair = {(at & bc) | (ac & bt), (at & bt) | (ac & bc)};
  endfunction : pair
  // ----------------------------------------------------------------
  // Pair stage: 1/8, 2/4, A/B, C/mark
  // ----------------------------------------------------------------
  always_comb begin
    {p_odd[0], p_even[0]} = pair(ch.t[occ_pkg::BIT_1], ch.c[occ_pkg::BIT_1],
                                 ch.t[occ_pkg::BIT_8], ch.c[occ_pkg::BIT_8]);
    {p_odd[1], p_even[1]} = pair(ch.t[occ_pkg::BIT_2], ch.c[occ_pkg::BIT_2],
                                 ch.t[occ_pkg::BIT_4], ch.c[occ_pkg::BIT_4]);
    {p_odd[2], p_even[2]} = pair(ch.t[occ_pkg::BIT_A], ch.c[occ_pkg::BIT_A],
                                 ch.t[occ_pkg::BIT_B], ch.c[occ_pkg::BIT_B]);
    {p_odd[3], p_even[3]} = pair(ch.t[occ_pkg::BIT_C], ch.c[occ_pkg::BIT_C],
                                 ch.t[occ_pkg::BIT_MARK], ch.c[occ_pkg::BIT_MARK]);
  end
  // ----------------------------------------------------------------
  // Portion and character stages, test lines force both rails
  // ----------------------------------------------------------------
  always_comb begin
    num_odd = (p_odd[0] & p_even[1]) | (p_even[0] & p_odd[1]) | test_num;
    num_even = (p_odd[0] & p_odd[1]) | (p_even[0] & p_even[1]) | test_num;
    zmc_odd = (p_odd[2] & p_even[3]) | (p_even[2] & p_odd[3]) | test_zone;
    zmc_even = (p_odd[2] & p_odd[3]) | (p_even[2] & p_even[3]) | test_zone;
    res.odd = (num_odd & zmc_even) | (num_even & zmc_odd);
    res.even = (num_odd & zmc_odd) | (num_even & zmc_even);
    // Check bits restore odd parity of each forwarded portion
    res.num_cbit = num_even;
    res.zone_cbit = p_even[2];
  end
endmodule : parity_checker
`default_nettype wire

//--- pkg/occ_pkg.sv
// Purpose: Shared constants and carriers for the operand channel check logic
// Assumes: 8-bit characters ordered 1,2,4,8,A,B,C,mark from bit 0 upward
// Notes: Register map is reached over APB, one aligned word per register
package occ_pkg;
  // ----------------------------------------------------------------
  // Character layout
  // ----------------------------------------------------------------
  localparam int BIT_1 = 0;
  localparam int BIT_2 = 1;
  localparam int BIT_4 = 2;
  localparam int BIT_8 = 3;
  localparam int BIT_A = 4;
  localparam int BIT_B = 5;
  localparam int BIT_C = 6;
  localparam int BIT_MARK = 7;
  localparam logic [7:0] HOLD_CLEAR_VAL = 8'h40;
  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_CLEAR = 12'h004;
  localparam logic [11:0] OFF_ENABLE = 12'h008;
  localparam logic [11:0] OFF_HOLD = 12'h00C;
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam int IND_READ_VC = 0;
  localparam int IND_OPND_VC = 1;
  localparam int IND_SET_CHK = 2;
  localparam int IND_SEL_CHK = 3;
  // Dual-rail character: true and complement lines
  typedef struct packed {
    logic [7:0] t;
    logic [7:0] c;
  } rail_char_t;
  // Results of one parity checker
  typedef struct packed {
    logic odd;
    logic even;
    logic num_cbit;
    logic zone_cbit;
  } vc_res_t;
  // APB request from the master
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;
endpackage : occ_pkg

//--- sim/datapath_model.sv
// Purpose: Far-side datapath model feeding the read channel and sources
// Assumes: Bench picks the read character and any injected rail faults
// Notes: Source registers hold fixed odd-parity characters
`timescale 1ns/1ps
`default_nettype none
module datapath_model (
  input wire logic [7:0] char_in,
  input wire logic [7:0] rail_fault,
  output occ_pkg::rail_char_t read_path,
  output logic [7:0] io_data_reg_one,
  output logic [7:0] io_data_reg_two,
  output logic [7:0] op_modifier
);
  // Complement rail mirrors the true rail unless a fault is injected
  assign read_path.t = char_in;
  assign read_path.c = ~char_in ^ rail_fault;
  // Distinct patterns, so a wrong gate shows on the operand channel
  assign io_data_reg_one = 8'h01;
  assign io_data_reg_two = 8'h13;
  assign op_modifier = 8'h80;
endmodule : datapath_model
`default_nettype wire

//--- sim/test_operand_channel_check_logic.sv
// Purpose: Self-checking bench for the operand channel check logic
// Assumes: One APB access answers within a few cycles
// Notes: Each scenario task drives the block and judges the result
`timescale 1ns/1ps
`default_nettype none
module test_operand_channel_check_logic;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [7:0] char_in, rail_fault, aep, opch, io1, io2, opm;
  logic ld_rd, ld_ad, clr_h, smp, stop, irq, ce;
  logic [3:0] gate, ind;
  logic [2:0] ctest;
  logic [1:0] rcb, ocb;
  occ_pkg::rail_char_t rp;
  int fails, comparisons, cycles;

  datapath_model partner (.char_in(char_in), .rail_fault(rail_fault), .read_path(rp),
    .io_data_reg_one(io1), .io_data_reg_two(io2), .op_modifier(opm));
  operand_channel_check_logic dut (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .read_path(rp),
    .address_exit_path(aep), .load_hold_from_read_path(ld_rd),
    .load_hold_from_address_path(ld_ad), .clear_hold(clr_h), .source_gate(gate),
    .io_data_reg_one(io1), .io_data_reg_two(io2), .op_modifier(opm),
    .error_sample(smp), .check_test(ctest), .operand_channel(opch), .read_cbits(rcb),
    .operand_cbits(ocb), .indicators(ind), .machine_stop(stop), .irq(irq));

  // Clock and hang guard; the ceiling is far above the scenario length
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // Request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) fails++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic sample();
    smp <= 1'b1;
    cyc(1);
    smp <= 1'b0;
    cyc(2);
  endtask : sample

  task automatic clear_ind();
    apb(1'b1, occ_pkg::OFF_CLEAR, 32'h0000000F);
    cyc(2);
  endtask : clear_ind

  // One-cycle pulse of {clear, load from address, load from read}
  task automatic pulse(input logic [2:0] p);
    {clr_h, ld_ad, ld_rd} <= p;
    cyc(1);
    {clr_h, ld_ad, ld_rd} <= 3'b000;
    cyc(1);
  endtask : pulse

  task automatic t_reset();
    check("ind_reset", ind, 4'h0);
    check("stop_reset", stop, 1'b0);
    apb(1'b0, occ_pkg::OFF_HOLD, 32'h0);
    check("hold_reset", rdv, 32'h40);
    check("slverr_ok", erv, 1'b0);
    apb(1'b0, occ_pkg::OFF_ENABLE, 32'h0);
    check("enable_reset", rdv, 32'h0);
  endtask : t_reset

  // Good, even and broken-rail characters on the read channel
  task automatic t_read_vc();
    logic [7:0] ch [5] = '{8'h01, 8'h1A, 8'h35, 8'h01, 8'h07};
    logic [7:0] fl [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h08};
    for (int i = 0; i < 5; i++) begin
      char_in <= ch[i];
      rail_fault <= fl[i];
      cyc(3);
      check("ind_unsampled", ind, 4'h0);
      if (i < 2) check("read_cbits", rcb, {~^ch[i][5:4], ~^ch[i][3:0]});
      sample();
      check("read_vc", ind[0], i > 1);
      check("stop", stop, i > 1);
      clear_ind();
    end
    char_in <= 8'h40;
    rail_fault <= 8'h00;
  endtask : t_read_vc

  task automatic t_hold();
    char_in <= 8'h1A;
    aep <= 8'h2C;
    pulse(3'b100);
    apb(1'b0, occ_pkg::OFF_HOLD, 32'h0);
    check("hold_cleared", rdv, 32'h40);
    pulse(3'b001);
    apb(1'b0, occ_pkg::OFF_HOLD, 32'h0);
    check("hold_read_path", rdv, 32'h1A);
    sample();
    check("operand_chan", opch, 8'h1A);
    check("operand_cbits", ocb, 2'b01);
    check("ind_balanced", ind, 4'h0);
    pulse(3'b100);
    pulse(3'b010);
    apb(1'b0, occ_pkg::OFF_HOLD, 32'h0);
    check("hold_addr_path", rdv, 32'h2C);
    pulse(3'b010);
    sample();
    check("set_chk", ind, 4'h4);
    pulse(3'b100);
    clear_ind();
    sample();
    check("set_chk_rebal", ind, 4'h0);
    char_in <= 8'h40;
  endtask : t_hold

  // Each single gate, then none and two at once
  task automatic t_select();
    logic [3:0] g [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h6};
    logic [7:0] v [4] = '{8'h40, 8'h01, 8'h13, 8'h80};
    // No gate leaves an all-zero channel, which the operand checker refuses too
    logic [3:0] e [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hA, 4'h8};
    for (int i = 0; i < 6; i++) begin
      gate <= g[i];
      cyc(2);
      if (i < 4) check("operand_chan", opch, v[i]);
      sample();
      check("select_chk", ind, e[i]);
      gate <= 4'h1;
      clear_ind();
    end
  endtask : t_select

  // Switch pressed, one sampled cycle, every expected light on
  task automatic t_check_test();
    logic [3:0] e [3] = '{4'hA, 4'hB, 4'hB};
    for (int i = 0; i < 3; i++) begin
      ctest <= 3'(1 << i);
      cyc(3);
      sample();
      ctest <= 3'b000;
      cyc(3);
      check("test_ind", ind, e[i]);
      check("test_stop", stop, 1'b1);
      clear_ind();
      check("stop_cleared", stop, 1'b0);
    end
  endtask : t_check_test

  // Clock enable low: a bad character, a load and a sample all ignored
  task automatic t_freeze();
    char_in <= 8'h03;
    ce <= 1'b0;
    cyc(1);
    pulse(3'b001);
    sample();
    check("frozen_ind", ind, 4'h0);
    char_in <= 8'h40;
    ce <= 1'b1;
    cyc(1);
    sample();
    check("thawed_ind", ind, 4'h0);
    apb(1'b0, occ_pkg::OFF_HOLD, 32'h0);
    check("frozen_hold", rdv, 32'h40);
  endtask : t_freeze

  task automatic t_irq();
    apb(1'b1, occ_pkg::OFF_ENABLE, 32'h2);
    char_in <= 8'h03;
    cyc(1);
    sample();
    check("irq_masked", irq, 1'b0);
    apb(1'b1, occ_pkg::OFF_ENABLE, 32'h1);
    cyc(2);
    check("irq_raised", irq, 1'b1);
    apb(1'b0, occ_pkg::OFF_ENABLE, 32'h0);
    check("enable_read", rdv, 32'h1);
    apb(1'b1, occ_pkg::OFF_STATUS, 32'h0);
    apb(1'b0, occ_pkg::OFF_STATUS, 32'h0);
    check("status_sticky", rdv, 32'h1);
    char_in <= 8'h40;
    clear_ind();
    check("irq_cleared", irq, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped_err", erv, 1'b1);
    check("unmapped_data", rdv, 32'h0);
  endtask : t_irq

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, ld_rd, ld_ad, clr_h, smp} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    char_in = 8'h40;
    rail_fault = 8'h00;
    aep = 8'h40;
    gate = 4'h1;
    ctest = 3'b000;
    ce = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    t_reset();
    t_read_vc();
    t_hold();
    t_select();
    t_freeze();
    t_check_test();
    t_irq();
    summarize();
  end
endmodule : test_operand_channel_check_logic
`default_nettype wire
